// file: verilog/bios_flash_interface_select.sv
// How it works
// - Strap high picks programming interface, low picks host bus interface.
// - Host mode detects hub-style or LPC cycles; read and write are told apart for hub-style only.
// - Normal erase uses eleven sectors: 32K boot, two 8K, 16K, seven 64K.
// - Uniform erase uses eight aligned 64K sectors.
// - Sector addresses decode from the fixed memory map.
// - Automation starts only on a valid command sequence.
// - Program and erase take fixed durations independent of wear.
// - Reset low blocks writes, clears automation, floats lines, returns read.
// - Init input acts like reset for mode, busy and cycle style in host mode.
// - Frame assertion in host mode starts a cycle and samples its start nibble.
// - Lock low refuses top 64K in hub mode or for a uniform erase, otherwise top 32K in LPC and programming modes.
module bios_flash_interface_select
    import flash_sel_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pins
    input wire logic interface_select_strap,
    input wire logic init_n,
    input wire logic frame_n,
    input wire logic top_sector_lock_n,
    input wire logic [3:0] lad_in,
    output logic [3:0] lad_out,
    output logic lad_oe,
    // Decoded write from active interface
    input wire logic wr_valid,
    input wire logic [18:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Status
    output logic prog_if_en,
    output logic host_if_en,
    output logic hub_style_cycle,
    output logic cycle_write,
    output logic cycle_start,
    output logic busy,
    output logic refused,
    output logic [3:0] op_sector
);
    logic [1:0] strap_sync, init_sync, frame_sync, lock_sync;
    logic [3:0] lad_s1, lad_s2;
    logic strap_held, captured, frame_q;
    logic next_strap_held, next_captured;
    cmd_mode_e mode, next_mode;
    logic [31:0] timer, next_timer;
    logic [18:0] op_addr, next_op_addr;
    logic uniform, next_uniform, next_busy, next_refused;
    logic [3:0] next_op_sector, dec_sector;
    logic dec_boot, next_hub, next_write, soft_rst;
    logic prot_hit;

    // Pin synchronisers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_sync <= 2'h3;
            frame_sync <= 2'h3;
            lock_sync <= 2'h0;
            lad_s1 <= 4'hf;
            lad_s2 <= 4'hf;
            frame_q <= 1'b1;
        end else begin
            init_sync <= {init_sync[0], init_n};
            frame_sync <= {frame_sync[0], frame_n};
            lock_sync <= {lock_sync[0], top_sector_lock_n};
            lad_s1 <= lad_in;
            lad_s2 <= lad_s1;
            frame_q <= frame_sync[1];
        end
    end

    // Strap synchroniser runs through reset so the level is ready at release
    always_ff @(posedge clk) begin
        strap_sync <= {strap_sync[0], interface_select_strap};
    end

    // Strap caught once after release; later changes ignored
    always_comb begin
        next_strap_held = strap_held;
        next_captured = 1'b1;
        if (!captured) begin
            next_strap_held = strap_sync[1];
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_held <= 1'b0;
            captured <= 1'b0;
        end else begin
            strap_held <= next_strap_held;
            captured <= next_captured;
        end
    end

    assign prog_if_en = captured && strap_held;
    assign host_if_en = captured && !strap_held;
    // Init behaves as a second reset only in host mode
    assign soft_rst = host_if_en && !init_sync[1];
    assign cycle_start = host_if_en && frame_q && !frame_sync[1];
    // Line driver stays off; read data path lives elsewhere
    assign lad_out = 4'h0;
    assign lad_oe = 1'b0;

    // Cycle style from the start nibble of each framed cycle
    always_comb begin
        next_hub = hub_style_cycle;
        next_write = cycle_write;
        if (soft_rst) begin
            next_hub = 1'b0;
            next_write = 1'b0;
        end else if (cycle_start) begin
            next_hub = (lad_s2 == START_HUB_RD) || (lad_s2 == START_HUB_WR);
            next_write = lad_s2 == START_HUB_WR;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hub_style_cycle <= 1'b0;
            cycle_write <= 1'b0;
        end else begin
            hub_style_cycle <= next_hub;
            cycle_write <= next_write;
        end
    end

    sector_decode u_dec (
        .addr(wr_addr),
        .uniform(uniform),
        .sector(dec_sector),
        .boot(dec_boot)
    );

    // Top region guard; the boot area only outside hub-style cycles, so in LPC and programming modes
    // Uniform scheme counts only for a pending erase, never for a later program
    always_comb begin
        if (hub_style_cycle || (mode == MODE_SETUP && uniform)) begin
            prot_hit = !lock_sync[1] && wr_addr[18:16] == 3'h7;
        end else begin
            prot_hit = !lock_sync[1] && dec_boot;
        end
    end

    // Command interface: read, setup, program, busy
    always_comb begin
        next_mode = mode;
        next_timer = timer;
        next_op_addr = op_addr;
        next_uniform = uniform;
        next_busy = busy;
        next_refused = refused;
        next_op_sector = op_sector;
        unique case (mode)
            MODE_READ: begin
                if (wr_valid && wr_data == CMD_SETUP) begin
                    next_mode = MODE_SETUP;
                    next_uniform = 1'b0;
                end else if (wr_valid && wr_data == CMD_UNIFORM) begin
                    next_mode = MODE_SETUP;
                    next_uniform = 1'b1;
                end else if (wr_valid && wr_data == CMD_PROGRAM) begin
                    next_mode = MODE_PROG;
                end
            end
            MODE_SETUP: begin
                if (wr_valid) begin
                    next_mode = MODE_READ;
                    if (wr_data == CMD_CONFIRM) begin
                        next_refused = prot_hit;
                        if (!prot_hit) begin
                            next_mode = MODE_BUSY;
                            next_busy = 1'b1;
                            next_op_sector = dec_sector;
                            next_timer = 32'(ERASE_CYC - 1);
                        end
                    end
                end
            end
            MODE_PROG: begin
                if (wr_valid) begin
                    next_refused = prot_hit;
                    next_mode = prot_hit ? MODE_READ : MODE_BUSY;
                    next_busy = !prot_hit;
                    next_op_addr = wr_addr;
                    next_timer = 32'(PROG_CYC - 1);
                end
            end
            MODE_BUSY: begin
                if (timer == 32'h0) begin
                    next_mode = MODE_READ;
                    next_busy = 1'b0;
                end else begin
                    next_timer = timer - 32'h1;
                end
            end
        endcase
        if (soft_rst) begin
            next_mode = MODE_READ;
            next_busy = 1'b0;
            next_timer = 32'h0;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= MODE_READ;
            timer <= 32'h0;
            op_addr <= 19'h0;
            uniform <= 1'b0;
            busy <= 1'b0;
            refused <= 1'b0;
            op_sector <= 4'h0;
        end else begin
            mode <= next_mode;
            timer <= next_timer;
            op_addr <= next_op_addr;
            uniform <= next_uniform;
            busy <= next_busy;
            refused <= next_refused;
            op_sector <= next_op_sector;
        end
    end

    // Checks
    a_strap_held: assert property (@(posedge clk) disable iff (!rstn)
        captured |=> $stable(strap_held)) else $error("strap changed");
    a_if_exclusive: assert property (@(posedge clk) disable iff (!rstn)
        !(prog_if_en && host_if_en)) else $error("both interfaces on");
    a_init_clears: assert property (@(posedge clk) disable iff (!rstn)
        soft_rst |=> mode == MODE_READ && !busy) else $error("init ignored");
    a_busy_source: assert property (@(posedge clk) disable iff (!rstn)
        $rose(busy) |-> $past(wr_valid)) else $error("busy without command");
    a_prog_time: assert property (@(posedge clk) disable iff (!rstn)
        (mode == MODE_PROG && wr_valid && !prot_hit && !soft_rst) |=> busy[*8])
        else $error("program too short");
    a_lock_refuse: assert property (@(posedge clk) disable iff (!rstn)
        (mode == MODE_PROG && wr_valid && prot_hit) |=> !busy && refused)
        else $error("locked write ran");
    a_start_hub: assert property (@(posedge clk) disable iff (!rstn)
        (cycle_start && !soft_rst && lad_s2 == START_HUB_WR) |=> hub_style_cycle && cycle_write)
        else $error("hub write not seen");
    a_lines_float: assert property (@(posedge clk) disable iff (!rstn)
        !lad_oe) else $error("lines driven");
    c_erase: cover property (@(posedge clk) disable iff (!rstn)
        mode == MODE_SETUP ##1 mode == MODE_BUSY);
    c_hub: cover property (@(posedge clk) disable iff (!rstn) $rose(hub_style_cycle));
    c_refuse: cover property (@(posedge clk) disable iff (!rstn) $rose(refused));
endmodule // bios_flash_interface_select

// file: verilog/flash_sel_pkg.sv
package flash_sel_pkg;
    // Array geometry
    localparam int ADDR_W = 19;
    localparam logic [18:0] BOOT_BASE = 19'h78000;
    localparam logic [18:0] BOOT_TOP = 19'h7ffff;
    localparam logic [18:0] SMALL1_BASE = 19'h76000;
    localparam logic [18:0] SMALL0_BASE = 19'h74000;
    localparam logic [18:0] MID_BASE = 19'h70000;
    localparam int MAIN_LSB = 16;
    localparam logic [3:0] SECTOR_COUNT = 4'hb;
    localparam logic [3:0] UNIFORM_COUNT = 4'h8;
    // Cycle start nibbles on the data lines
    localparam logic [3:0] START_LPC = 4'h0;
    localparam logic [3:0] START_HUB_RD = 4'hd;
    localparam logic [3:0] START_HUB_WR = 4'he;
    // Command interface codes
    localparam logic [7:0] CMD_SETUP = 8'h20;
    localparam logic [7:0] CMD_UNIFORM = 8'h30;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_READ = 8'hff;
    // Fixed operation times
    localparam int CLK_MHZ = 40;
    localparam int PROG_US = 20;
    localparam int ERASE_US = 500;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
    typedef enum logic [1:0] {MODE_READ, MODE_SETUP, MODE_PROG, MODE_BUSY} cmd_mode_e;
endpackage

// file: verilog/sector_decode.sv
module sector_decode
    import flash_sel_pkg::*;
(
    // Address and scheme
    input wire logic [18:0] addr,
    input wire logic uniform,
    // Result
    output logic [3:0] sector,
    output logic boot
);
    // Sector number from address in either scheme
    always_comb begin
        boot = addr >= BOOT_BASE;
        if (uniform || addr < MID_BASE) begin
            sector = {1'b0, addr[18:16]};
        end else if (addr >= BOOT_BASE) begin
            sector = 4'ha;
        end else if (addr >= SMALL1_BASE) begin
            sector = 4'h9;
        end else if (addr >= SMALL0_BASE) begin
            sector = 4'h8;
        end else begin
            sector = 4'h7;
        end
    end
endmodule // sector_decode

// file: verification/host_model.sv
module host_model (
    // Bus side
    input wire logic clk,
    output logic frame_n,
    output logic [3:0] lad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic driving = 1'b0;
    logic [3:0] nib = 4'h0;
    logic [3:0] pat = 4'h5;
    // Released lines toggle so a stale nibble never reads as valid
    always @(posedge clk) pat <= ~pat;
    assign lad_in = driving ? nib : pat;
    initial frame_n = 1'b1;
    // Start nibble stands with frame low for two cycles
    task automatic send_start(input logic [3:0] n);
        @(posedge clk);
        frame_n <= 1'b0;
        driving <= 1'b1;
        nib <= n;
        repeat (2) @(posedge clk);
        frame_n <= 1'b1;
        driving <= 1'b0;
    endtask
endmodule // host_model

// file: verification/bios_flash_interface_select_tb.sv
module bios_flash_interface_select_tb;
    import flash_sel_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, strap = 1'b0, init_n = 1'b1, lock_n = 1'b1;
    logic wr_valid = 1'b0;
    logic [18:0] wr_addr = 19'h0;
    logic [7:0] wr_data = 8'h0;
    logic frame_n, lad_oe, prog_if_en, host_if_en, hub, cyc_wr, cyc_start, busy, refused;
    logic [3:0] lad_in, lad_out, op_sector;
    int miscompares = 0, n_tests = 0, n1, n2;
    localparam logic [18:0] SA[11] = '{19'h78000, 19'h77fff, 19'h74000, 19'h73fff, 19'h6ffff,
        19'h50000, 19'h4ffff, 19'h30000, 19'h2ffff, 19'h10000, 19'h00000};
    localparam logic [3:0] NIB[3] = '{START_HUB_RD, START_HUB_WR, START_LPC};
    initial forever #12.5 clk = ~clk;
    host_model host (.clk(clk), .frame_n(frame_n), .lad_in(lad_in));
    bios_flash_interface_select DUT (.clk(clk), .rstn(rstn), .interface_select_strap(strap),
        .init_n(init_n), .frame_n(frame_n), .top_sector_lock_n(lock_n), .lad_in(lad_in),
        .lad_out(lad_out), .lad_oe(lad_oe), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data), .prog_if_en(prog_if_en), .host_if_en(host_if_en),
        .hub_style_cycle(hub), .cycle_write(cyc_wr), .cycle_start(cyc_start), .busy(busy),
        .refused(refused), .op_sector(op_sector));
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Strap settles while reset is held, well before release
    task automatic do_reset(input logic s);
        @(posedge clk);
        rstn <= 1'b0;
        strap <= s;
        tick(4);
        chk(busy, 0);
        chk(lad_oe, 0);
        chk(lad_out, 0);
        @(posedge clk);
        rstn <= 1'b1;
        tick(3);
    endtask
    task automatic wr(input logic [7:0] d, input logic [18:0] a);
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= d;
        wr_addr <= a;
        @(posedge clk);
        wr_valid <= 1'b0;
    endtask
    task automatic op(input logic [7:0] c, input logic [7:0] d, input logic [18:0] a);
        wr(c, a);
        wr(d, a);
        tick(2);
    endtask
    // Init held low four cycles, then time for the synchroniser to clear
    task automatic pulse_init();
        @(posedge clk);
        init_n <= 1'b0;
        repeat (4) @(posedge clk);
        init_n <= 1'b1;
        tick(4);
    endtask
    // Bounded count of cycles while busy stays high
    task automatic busy_len(output int n);
        n = 2; // Op already spent two of the busy cycles
        while (busy === 1'b1 && n < 25000) begin
            tick(1);
            n++;
        end
        if (n >= 25000) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic frame(input logic [3:0] nb);
        int k;
        host.send_start(nb);
        #1; // Start pulse is only settled after the launching edge
        for (k = 0; k < 10 && cyc_start !== 1'b1; k++) tick(1);
        if (k >= 10) begin
            miscompares++;
            complete_run();
        end
        tick(2);
    endtask
    initial begin
        do_reset(1'b0);
        chk({host_if_en, prog_if_en}, 2'b10);
        @(posedge clk);
        strap <= 1'b1;
        tick(4);
        chk({host_if_en, prog_if_en}, 2'b10);
        do_reset(1'b1);
        chk({host_if_en, prog_if_en}, 2'b01);
        // Init pin is ignored in programming mode, so automation survives it
        op(CMD_SETUP, CMD_CONFIRM, 19'h0);
        pulse_init();
        chk(busy, 1);
        do_reset(1'b0);
        op(CMD_SETUP, CMD_CONFIRM, 19'h0);
        pulse_init();
        chk(busy, 0);
        // Cycle styles are told apart by the start nibble
        for (int i = 0; i < 3; i++) begin
            frame(NIB[i]);
            chk(hub, i < 2);
            if (i < 2) chk(cyc_wr, i);
        end
        // Broken sequences leave the array idle
        op(CMD_SETUP, CMD_READ, 19'h0);
        chk(busy, 0);
        op(CMD_CONFIRM, CMD_CONFIRM, 19'h0);
        chk(busy, 0);
        // Each erase is cut short by reset once its sector is seen
        for (int i = 0; i < 11; i++) begin
            do_reset(1'b0);
            op(CMD_SETUP, CMD_CONFIRM, SA[i]);
            chk(busy, 1);
            chk(op_sector, 10 - i);
        end
        for (int k = 0; k < 8; k += 3) begin
            do_reset(1'b0);
            op(CMD_UNIFORM, CMD_CONFIRM, {k[2:0], 16'h1234});
            chk(op_sector, k);
        end
        do_reset(1'b0);
        op(CMD_PROGRAM, 8'h5a, 19'h12345);
        busy_len(n1);
        op(CMD_PROGRAM, 8'ha5, 19'h6789a);
        busy_len(n2);
        chk(n1, PROG_CYC);
        chk(n2, PROG_CYC);
        op(CMD_SETUP, CMD_CONFIRM, 19'h20000);
        busy_len(n1);
        chk(n1, ERASE_CYC);
        @(posedge clk);
        lock_n <= 1'b0;
        frame(START_LPC);
        op(CMD_SETUP, CMD_CONFIRM, 19'h78000);
        chk({refused, busy}, 2'b10);
        op(CMD_SETUP, CMD_CONFIRM, 19'h70000);
        chk({refused, busy}, 2'b01);
        do_reset(1'b0);
        frame(START_HUB_RD);
        op(CMD_SETUP, CMD_CONFIRM, 19'h70000);
        chk({refused, busy}, 2'b10);
        complete_run();
    end
endmodule // bios_flash_interface_select_tb
